// ==== rits_pkg.sv ====
package rits_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 25;
    localparam int HARD_ASSERT_US  = 100;
    localparam int CORE_LOCK_US    = 100;
    localparam int AUX_LOCK_US     = 50;
    localparam int HARD_ASSERT_CYC = HARD_ASSERT_US * CLK_MHZ;
    localparam int CORE_LOCK_CYC   = CORE_LOCK_US * CLK_MHZ;
    localparam int AUX_LOCK_CYC    = AUX_LOCK_US * CLK_MHZ;
    localparam int STRAP_SETUP_CYC = 4;
    localparam int STRAP_HOLD_CYC  = 2;
    localparam int SOFT_MIN_CYC    = 3;
    localparam int CNT_W           = 12;

    // ------------------------------------------------------------
    // Straps and pin bundle
    // ------------------------------------------------------------
    localparam int CFG_W = 8;
    localparam int PLL_W = 4;

    typedef struct packed {
        logic [PLL_W-1:0] pllRatio;
        logic [CFG_W-1:0] options;
    } rits_straps_t;

    typedef struct packed {
        logic         hardResetInN;
        logic         softResetInN;
        logic         realTimeTick;
        logic         corePllLock;
        logic         localBusPllLock;
        logic         pciClockLock;
        rits_straps_t straps;
    } rits_pins_t;

    localparam int PINS_W = $bits(rits_pins_t);

    typedef enum logic [1:0] {
        ST_HARD = 2'b00,
        ST_HOLD = 2'b01,
        ST_LOCK = 2'b10,
        ST_RUN  = 2'b11
    } rits_state_t;

endpackage

// ==== rits_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rits_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    // Stage one feeds stage two only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule
`default_nettype wire

// ==== rits_reset_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Tick input synchronised to platform clock
// - Tick has no rate limit; low allowed
// - Straps set up four cycles; captured
// - PLLs lock within 100 or 50 us
module rits_reset_tick (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  hardResetInN,
    input  wire logic                  softResetInN,
    input  wire logic                  realTimeTick,
    input  wire logic                  corePllLock,
    input  wire logic                  localBusPllLock,
    input  wire logic                  pciClockLock,
    input  wire rits_pkg::rits_straps_t straps,
    output logic                       tickSample,
    output logic                       tickEdge,
    output logic                       coreResetN,
    output logic                       coreSoftReset,
    output rits_pkg::rits_straps_t     strapsCaptured,
    output logic                       strapSetupError,
    output logic                       strapHoldError,
    output logic                       hardShortError,
    output logic                       lockError
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    rits_pkg::rits_pins_t pinsRaw;
    rits_pkg::rits_pins_t pinsSync;

    assign pinsRaw = '{hardResetInN: hardResetInN, softResetInN: softResetInN,
                       realTimeTick: realTimeTick, corePllLock: corePllLock,
                       localBusPllLock: localBusPllLock, pciClockLock: pciClockLock,
                       straps: straps};

    rits_sync #(.W(rits_pkg::PINS_W)) pinSync (
        .clock   (clock),
        .reset_n (reset_n),
        .d       (pinsRaw),
        .q       (pinsSync)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rits_pkg::rits_state_t       fsm;
        rits_pkg::rits_straps_t      straps;
        rits_pkg::rits_straps_t      prevStraps;
        logic [2:0]                  stableCnt;
        logic [rits_pkg::CNT_W-1:0]  hardCnt;
        logic [rits_pkg::CNT_W-1:0]  lockCnt;
        logic [1:0]                  softCnt;
        logic                        softReset;
        logic                        coreResetN;
        logic                        tick;
        logic                        tickEdge;
        logic                        setupErr;
        logic                        holdErr;
        logic                        hardShort;
        logic                        lockErr;
    } rits_core_t;

    rits_core_t s;
    rits_core_t next_s;
    logic       hardN;
    logic       allLocked;
    logic       releaseNow;

    assign hardN     = pinsSync.hardResetInN;
    assign allLocked = pinsSync.corePllLock && pinsSync.localBusPllLock && pinsSync.pciClockLock;
    assign releaseNow = (s.fsm == rits_pkg::ST_HARD) && hardN;

    always_comb begin
        next_s = s;
        // Tick: one more flop after sync, edge for the counters
        next_s.tick     = pinsSync.realTimeTick;
        next_s.tickEdge = pinsSync.realTimeTick && !s.tick;
        // Strap stability tracking for the setup window
        next_s.prevStraps = pinsSync.straps;
        if (pinsSync.straps != s.prevStraps) begin
            next_s.stableCnt = 3'h0;
        end else if (s.stableCnt != 3'h7) begin
            next_s.stableCnt = s.stableCnt + 3'h1;
        end
        if (!hardN) begin
            next_s.coreResetN = 1'b0;
            next_s.softReset  = 1'b0;
            next_s.softCnt    = 2'h0;
            if (s.fsm != rits_pkg::ST_HARD) begin
                next_s.fsm     = rits_pkg::ST_HARD;
                next_s.hardCnt = {{(rits_pkg::CNT_W-1){1'b0}}, 1'b1};
            end else if (s.hardCnt != {rits_pkg::CNT_W{1'b1}}) begin
                next_s.hardCnt = s.hardCnt + 12'h001;
            end
        end else begin
            case (s.fsm)
                rits_pkg::ST_HARD: begin
                    next_s.straps    = pinsSync.straps;
                    next_s.setupErr  = 32'(s.stableCnt) < rits_pkg::STRAP_SETUP_CYC - 1;
                    next_s.hardShort = 32'(s.hardCnt) < rits_pkg::HARD_ASSERT_CYC;
                    next_s.holdErr   = 1'b0;
                    next_s.lockErr   = 1'b0;
                    next_s.lockCnt   = 12'h000;
                    next_s.fsm       = rits_pkg::ST_HOLD;
                end
                rits_pkg::ST_HOLD: begin
                    // Late strap change flagged, capture kept
                    if (pinsSync.straps != s.straps) begin
                        next_s.holdErr = 1'b1;
                    end
                    next_s.lockCnt = s.lockCnt + 12'h001;
                    if (32'(s.lockCnt) == rits_pkg::STRAP_HOLD_CYC - 1) begin
                        next_s.fsm     = rits_pkg::ST_LOCK;
                        next_s.lockCnt = 12'h000;
                    end
                end
                rits_pkg::ST_LOCK: begin
                    if (s.lockCnt != {rits_pkg::CNT_W{1'b1}}) begin
                        next_s.lockCnt = s.lockCnt + 12'h001;
                    end
                    // Waiting continues past a timeout; only flagged
                    if ((32'(s.lockCnt) >= rits_pkg::CORE_LOCK_CYC && !pinsSync.corePllLock) ||
                        (32'(s.lockCnt) >= rits_pkg::AUX_LOCK_CYC &&
                         !(pinsSync.localBusPllLock && pinsSync.pciClockLock))) begin
                        next_s.lockErr = 1'b1;
                    end
                    if (allLocked) begin
                        next_s.fsm        = rits_pkg::ST_RUN;
                        next_s.coreResetN = 1'b1;
                    end
                end
                rits_pkg::ST_RUN: begin
                    // Short soft pulses ignored as glitches
                    if (!pinsSync.softResetInN) begin
                        if (s.softCnt != 2'h3) begin
                            next_s.softCnt = s.softCnt + 2'h1;
                        end
                        if (32'(s.softCnt) >= rits_pkg::SOFT_MIN_CYC - 1) begin
                            next_s.softReset = 1'b1;
                        end
                    end else begin
                        next_s.softCnt   = 2'h0;
                        next_s.softReset = 1'b0;
                    end
                end
                default: begin
                    next_s.fsm = rits_pkg::ST_HARD;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tickSample      = s.tick;
    assign tickEdge        = s.tickEdge;
    assign coreResetN      = s.coreResetN;
    assign coreSoftReset   = s.softReset;
    assign strapsCaptured  = s.straps;
    assign strapSetupError = s.setupErr;
    assign strapHoldError  = s.holdErr;
    assign hardShortError  = s.hardShort;
    assign lockError       = s.lockErr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence seq_release;
        releaseNow;
    endsequence

    sequence seq_hold_window;
        (s.fsm == rits_pkg::ST_HOLD) [*2];
    endsequence

    a_tick_delay: assert property (@(posedge clock) disable iff (!reset_n)
        ($past(reset_n, 1) && $past(reset_n, 2) && $past(reset_n, 3)) |-> tickSample == $past(realTimeTick, 3))
        else $error("tick sample does not follow input by three cycles");

    a_tick_edge: assert property (@(posedge clock) disable iff (!reset_n)
        tickEdge |-> tickSample && !$past(tickSample))
        else $error("tick edge without rising sample");

    a_strap_capture: assert property (@(posedge clock) disable iff (!reset_n)
        seq_release |=> strapsCaptured == $past(pinsSync.straps))
        else $error("straps not captured at hard reset release");

    a_hold_window: assert property (@(posedge clock) disable iff (!reset_n)
        seq_release ##1 hardN [*2] |-> $past(s.fsm == rits_pkg::ST_HOLD) && (s.fsm == rits_pkg::ST_HOLD))
        else $error("hold window not two cycles");

    a_run_after_lock: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(coreResetN) |-> $past(allLocked) && $past(hardN))
        else $error("core reset released without lock");

    a_hard_forces: assert property (@(posedge clock) disable iff (!reset_n)
        (!hardN && $past(reset_n)) |=> !coreResetN && s.fsm == rits_pkg::ST_HARD)
        else $error("hard reset did not hold core");

    a_lock_timeout: assert property (@(posedge clock) disable iff (!reset_n)
        (s.fsm == rits_pkg::ST_LOCK && hardN && 32'(s.lockCnt) == rits_pkg::CORE_LOCK_CYC &&
         !pinsSync.corePllLock) |=> lockError)
        else $error("core lock timeout not flagged");

    a_hold_seq: assert property (@(posedge clock) disable iff (!reset_n)
        seq_release ##1 seq_hold_window |-> ##1 (s.fsm != rits_pkg::ST_HOLD))
        else $error("hold state lasted too long");

endmodule
`default_nettype wire

// ==== rits_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module rits_partner (
    input  wire logic              clock,
    output logic                   hardResetInN,
    output logic                   corePllLock,
    output logic                   localBusPllLock,
    output logic                   pciClockLock,
    output logic                   realTimeTick,
    output rits_pkg::rits_straps_t straps
);
    integer seed = 68;
    integer len;

    // Tick levels always last three or more cycles
    initial begin
        hardResetInN = 1'b0;
        {corePllLock, localBusPllLock, pciClockLock} = 3'h0;
        straps = 12'h000;
        realTimeTick = 1'b0;
        forever begin
            len = 3 + ($random(seed) & 7);
            repeat (len) @(negedge clock);
            realTimeTick = ~realTimeTick;
        end
    end

    task automatic hard_cycle(input int lowCyc, input int late, input int holdCyc,
                              input int coreDly, input int auxDly, input logic [11:0] v);
        @(negedge clock);
        hardResetInN = 1'b0;
        {corePllLock, localBusPllLock, pciClockLock} = 3'h0;
        straps = ~v;
        for (int i = 0; i < lowCyc; i++) begin
            @(negedge clock);
            if (i == lowCyc - late) straps = v;
        end
        hardResetInN = 1'b1;
        for (int i = 1; i <= 3000; i++) begin
            @(negedge clock);
            // Released pins float: from cycle holdCyc on, show a pattern that moves every cycle
            if (i >= holdCyc) straps = ~straps;
            corePllLock = (i >= coreDly);
            localBusPllLock = (i >= auxDly);
            pciClockLock = (i >= auxDly);
            if (i >= coreDly && i >= auxDly && i >= holdCyc) break;
        end
    endtask
endmodule
`default_nettype wire

// ==== rits_reset_tick_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rits_reset_tick_bench;
    logic                   clock = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   softResetInN = 1'b1;
    logic                   hardResetInN;
    logic                   corePllLock;
    logic                   localBusPllLock;
    logic                   pciClockLock;
    logic                   realTimeTick;
    rits_pkg::rits_straps_t straps;
    rits_pkg::rits_straps_t strapsCaptured;
    logic                   tickSample;
    logic                   tickEdge;
    logic                   coreResetN;
    logic                   coreSoftReset;
    logic                   strapSetupError;
    logic                   strapHoldError;
    logic                   hardShortError;
    logic                   lockError;
    logic                   hit;
    logic [11:0]            v;
    logic                   tickQ [$];
    integer                 nFail = 0;
    integer                 totalChecks = 0;
    integer                 cycles = 0;
    integer                 seed = 68;
    int                     lowCyc [6] = '{2600, 100, 2600, 2600, 2600, 2600};
    int                     late [6] = '{10, 10, 2, 10, 10, 10};
    int                     holdCyc [6] = '{5, 5, 5, 1, 5, 5};
    int                     coreDly [6] = '{40, 3, 3, 3, 2600, 3};
    int                     auxDly [6] = '{30, 3, 3, 3, 3, 1300};
    logic [3:0]             expErr [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h1};

    rits_reset_tick u_rits_reset_tick (
        .clock           (clock),
        .reset_n         (reset_n),
        .hardResetInN    (hardResetInN),
        .softResetInN    (softResetInN),
        .realTimeTick    (realTimeTick),
        .corePllLock     (corePllLock),
        .localBusPllLock (localBusPllLock),
        .pciClockLock    (pciClockLock),
        .straps          (straps),
        .tickSample      (tickSample),
        .tickEdge        (tickEdge),
        .coreResetN      (coreResetN),
        .coreSoftReset   (coreSoftReset),
        .strapsCaptured  (strapsCaptured),
        .strapSetupError (strapSetupError),
        .strapHoldError  (strapHoldError),
        .hardShortError  (hardShortError),
        .lockError       (lockError)
    );

    rits_partner u_rits_partner (
        .clock           (clock),
        .hardResetInN    (hardResetInN),
        .corePllLock     (corePllLock),
        .localBusPllLock (localBusPllLock),
        .pciClockLock    (pciClockLock),
        .realTimeTick    (realTimeTick),
        .straps          (straps)
    );

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finishTest();
        if (nFail == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial forever #20 clock = ~clock;

    // Guard against a hang in any wait below
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            nFail++;
            finishTest();
        end
    end

    // ------------------------------------------------------------
    // Tick reference: pin delayed three edges
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!reset_n) begin
            tickQ.delete();
        end else begin
            tickQ.push_back(realTimeTick);
            if (tickQ.size() > 5) void'(tickQ.pop_front());
        end
    end

    always @(negedge clock) begin
        if (tickQ.size() == 5) begin
            check(tickSample, tickQ[2]);
            check(tickEdge, tickQ[2] & ~tickQ[1]);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        for (int k = 0; k < 6; k++) begin
            v = 12'($random(seed));
            fork
                u_rits_partner.hard_cycle(lowCyc[k], late[k], holdCyc[k], coreDly[k], auxDly[k], v);
                begin
                    repeat (lowCyc[k] + (coreDly[k] > 10 ? coreDly[k] - 5 : 0)) @(negedge clock);
                    check(coreResetN, 1'b0);
                end
            join
            for (int w = 0; w < 20 && coreResetN !== 1'b1; w++) @(negedge clock);
            check(coreResetN, 1'b1);
            check(strapsCaptured, v);
            check({hardShortError, strapSetupError, strapHoldError, lockError}, expErr[k]);
        end
        // Three-cycle soft pulse acts, two-cycle pulse is ignored
        for (int p = 3; p >= 2; p--) begin
            hit = 1'b0;
            softResetInN = 1'b0;
            for (int i = 0; i < 10; i++) begin
                @(negedge clock);
                if (i == p - 1) softResetInN = 1'b1;
                hit = hit | coreSoftReset;
            end
            check(hit, p == 3);
            check(coreSoftReset, 1'b0);
        end
        finishTest();
    end
endmodule
`default_nettype wire
